// ===== rtl/vpm_pkg.sv
// constants for the vector priority and memory map block
package vpm_pkg;
    // ========================================
    // vectors
    localparam int unsigned NUM_VEC        = 46;
    localparam int unsigned VEC_W          = 6;
    localparam int unsigned LVL_W          = 3;
    localparam logic [5:0]  VEC_CORE_LO    = 6'h02;
    localparam logic [5:0]  VEC_CORE_HI    = 6'h05;
    localparam logic [5:0]  VEC_DBG_LO     = 6'h06;
    localparam logic [5:0]  VEC_DBG_HI     = 6'h0A;
    localparam logic [5:0]  VEC_SW2        = 6'h0B;
    localparam logic [5:0]  VEC_SW1        = 6'h0C;
    localparam logic [5:0]  VEC_SW0        = 6'h0D;
    localparam logic [5:0]  VEC_PER_LO     = 6'h10;
    localparam logic [5:0]  VEC_PER_HI     = 6'h2C;
    localparam logic [5:0]  VEC_CLK_SYNTH  = 6'h11;
    localparam logic [5:0]  VEC_LOW_SW     = 6'h2D;
    // reserved vectors: 0,1 (reset overlay), 14,15,21,33,34
    localparam logic [45:0] VEC_VALID_MASK = 46'h3FF9_FFDF_3FFC;
    // levels: internal code is documented level plus one
    localparam logic [2:0]  LVL_NONE       = 3'h0;
    localparam logic [2:0]  LVL_LOWEST     = 3'h1;
    localparam logic [2:0]  LVL_TOP        = 3'h4;
    // ========================================
    // addresses
    localparam int unsigned ADDR_W         = 24;
    localparam int unsigned TGT_W          = 19;
    localparam logic [23:0] VBASE_RST      = 24'h00_0000;
    localparam logic [23:0] PROG_FLASH_LO  = 24'h00_0000;
    localparam logic [23:0] PROG_FLASH_HI  = 24'h00_1FFF;
    localparam logic [23:0] PROG_RAM_LO    = 24'h00_8000;
    localparam logic [23:0] PROG_RAM_HI    = 24'h00_87FF;
    localparam logic [23:0] DATA_RAM_LO    = 24'h00_0000;
    localparam logic [23:0] DATA_RAM_HI    = 24'h00_07FF;
    localparam logic [23:0] DATA_PER_LO    = 24'h00_F000;
    localparam logic [23:0] DATA_PER_HI    = 24'h00_FFFF;
    localparam logic [23:0] DATA_DBG_LO    = 24'hFF_FF00;
    localparam logic [23:0] DATA_DBG_HI    = 24'hFF_FFFF;
    localparam int unsigned FLASH_WORDS    = 8192;
    localparam int unsigned RAM_WORDS      = 2048;
endpackage : vpm_pkg

// ===== rtl/vpm_top.sv
// interrupt arbiter, vector fetch address and memory decode
`timescale 1ns/1ps
`default_nettype none
module vpm_top #(
    parameter int unsigned NVEC = vpm_pkg::NUM_VEC
) (
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire logic [NVEC-1:0]    irq_req,
    input  wire logic [1:0]         dbg_level [6],
    input  wire logic [1:0]         per_level [NVEC],
    input  wire logic               clk_lock_irq,
    input  wire logic               clk_loss_irq,
    input  wire logic               vbase_we,
    input  wire logic [23:0]        vbase_wdata,
    input  wire logic               irq_ack,
    input  wire logic [23:0]        prog_addr,
    input  wire logic [23:0]        data_addr,
    input  wire logic               flash_unit_we,
    input  wire logic [12:0]        flash_unit_addr,
    input  wire logic [15:0]        flash_unit_wdata,
    input  wire logic               data_we,
    input  wire logic [15:0]        data_wdata,
    output logic [23:0]             vector_base,
    output logic                    irq_pending,
    output logic [5:0]              irq_vector,
    output logic [2:0]              irq_level,
    output logic                    fetch_valid,
    output logic [23:0]             fetch_addr,
    output logic [15:0]             prog_rdata,
    output logic                    prog_hit,
    output logic [15:0]             data_rdata,
    output logic                    data_hit,
    output logic                    data_per_sel,
    output logic                    data_dbg_sel
);
    // ========================================
    // helpers
    function automatic logic in_rng(input logic [23:0] a,
                                    input logic [23:0] lo,
                                    input logic [23:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction : in_rng

    function automatic logic [23:0] entry_addr(input logic [23:0] b,
                                               input logic [5:0] v);
        entry_addr = b + {17'h0_0000, v, 1'b0};
    endfunction : entry_addr

    // ========================================
    // vector base
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            vector_base <= vpm_pkg::VBASE_RST;
        end else if (vbase_we) begin
            vector_base <= vbase_wdata;
        end
    end

    // ========================================
    // level assignment
    logic [NVEC-1:0] req_eff;
    logic [2:0]      lvl [NVEC];
    always_comb begin
        for (int i = 0; i < NVEC; i++) begin
            req_eff[i] = irq_req[i] & vpm_pkg::VEC_VALID_MASK[i];
            lvl[i]     = vpm_pkg::LVL_NONE;
            if (6'(i) == vpm_pkg::VEC_CLK_SYNTH) begin
                req_eff[i] = clk_lock_irq | clk_loss_irq;
            end
            if (6'(i) >= vpm_pkg::VEC_CORE_LO &&
                6'(i) <= vpm_pkg::VEC_CORE_HI) begin
                lvl[i] = vpm_pkg::LVL_TOP;
            end else if (6'(i) >= vpm_pkg::VEC_DBG_LO &&
                         6'(i) <= vpm_pkg::VEC_DBG_HI) begin
                // level 0 code clamps up to level 1
                lvl[i] = (dbg_level[i-6] == 2'h0) ? 3'h2
                         : {1'b0, dbg_level[i-6]} + 3'h1;
            end else if (6'(i) == vpm_pkg::VEC_SW2) begin
                lvl[i] = 3'h3;
            end else if (6'(i) == vpm_pkg::VEC_SW1) begin
                lvl[i] = 3'h2;
            end else if (6'(i) == vpm_pkg::VEC_SW0) begin
                // level 0 shares code 1 with vector 45, which loses ties
                lvl[i] = 3'h1;
            end else if (6'(i) >= vpm_pkg::VEC_PER_LO &&
                         6'(i) <= vpm_pkg::VEC_PER_HI) begin
                // level 3 code clamps down to level 2
                lvl[i] = (per_level[i] == 2'h3) ? 3'h3
                         : {1'b0, per_level[i]} + 3'h1;
            end else if (6'(i) == vpm_pkg::VEC_LOW_SW) begin
                lvl[i] = vpm_pkg::LVL_LOWEST;
            end
        end
    end

    // ========================================
    // arbitration
    logic [5:0] win_vec;
    logic [2:0] win_lvl;
    logic       win_any;
    always_comb begin
        win_vec = 6'h00;
        win_lvl = vpm_pkg::LVL_NONE;
        win_any = 1'b0;
        // descending scan: ties go to the smaller vector
        for (int i = NVEC - 1; i >= 0; i--) begin
            if (req_eff[i] && lvl[i] != vpm_pkg::LVL_NONE &&
                lvl[i] >= win_lvl) begin
                win_vec = 6'(i);
                win_lvl = lvl[i];
                win_any = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_pending <= 1'b0;
            irq_vector  <= 6'h00;
            irq_level   <= vpm_pkg::LVL_NONE;
        end else begin
            irq_pending <= win_any;
            irq_vector  <= win_vec;
            irq_level   <= win_lvl;
        end
    end

    // ========================================
    // fetch address on acceptance
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_valid <= 1'b0;
            fetch_addr  <= 24'h00_0000;
        end else begin
            fetch_valid <= irq_ack && irq_pending;
            if (irq_ack && irq_pending) begin
                fetch_addr <= entry_addr(vector_base, irq_vector);
            end
        end
    end

    // ========================================
    // memories, word addressed
    logic [15:0] flash_mem [vpm_pkg::FLASH_WORDS];
    logic [15:0] ram_mem   [vpm_pkg::RAM_WORDS];
    logic        p_flash;
    logic        p_ram;
    logic        d_ram;
    assign p_flash = in_rng(prog_addr, vpm_pkg::PROG_FLASH_LO,
                            vpm_pkg::PROG_FLASH_HI);
    assign p_ram   = in_rng(prog_addr, vpm_pkg::PROG_RAM_LO,
                            vpm_pkg::PROG_RAM_HI);
    assign d_ram   = in_rng(data_addr, vpm_pkg::DATA_RAM_LO,
                            vpm_pkg::DATA_RAM_HI);

    always_ff @(posedge ref_clk) begin
        if (flash_unit_we) begin
            flash_mem[flash_unit_addr] <= flash_unit_wdata;
        end
        if (data_we && d_ram) begin
            ram_mem[data_addr[10:0]] <= data_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_rdata   <= 16'h0000;
            prog_hit     <= 1'b0;
            data_rdata   <= 16'h0000;
            data_hit     <= 1'b0;
            data_per_sel <= 1'b0;
            data_dbg_sel <= 1'b0;
        end else begin
            prog_hit <= p_flash | p_ram;
            if (p_flash) begin
                prog_rdata <= flash_mem[prog_addr[12:0]];
            end else if (p_ram) begin
                prog_rdata <= ram_mem[prog_addr[10:0]];
            end else begin
                prog_rdata <= 16'h0000;
            end
            data_hit     <= d_ram;
            data_rdata   <= d_ram ? ram_mem[data_addr[10:0]] : 16'h0000;
            data_per_sel <= in_rng(data_addr, vpm_pkg::DATA_PER_LO,
                                   vpm_pkg::DATA_PER_HI);
            data_dbg_sel <= in_rng(data_addr, vpm_pkg::DATA_DBG_LO,
                                   vpm_pkg::DATA_DBG_HI);
        end
    end

    // ========================================
    // checks
    property p_never_reserved;
        @(posedge ref_clk) disable iff (!rst_n)
        irq_pending |-> vpm_pkg::VEC_VALID_MASK[irq_vector];
    endproperty
    a_never_reserved: assert property (p_never_reserved)
        else $error("reserved vector presented");

    property p_core_top;
        @(posedge ref_clk) disable iff (!rst_n)
        (irq_pending && irq_vector >= 6'h02 && irq_vector <= 6'h05)
        |-> irq_level == 3'h4;
    endproperty
    a_core_top: assert property (p_core_top)
        else $error("core exception not at top level");

    property p_low_sw;
        @(posedge ref_clk) disable iff (!rst_n)
        (irq_pending && irq_vector == 6'h2D) |-> irq_level == 3'h1;
    endproperty
    a_low_sw: assert property (p_low_sw)
        else $error("lowest software interrupt level wrong");

    property p_low_only_alone;
        @(posedge ref_clk) disable iff (!rst_n)
        (irq_pending && irq_vector == 6'h2D)
        |-> $past(req_eff & ~46'h2000_0000_0000) == 46'h0;
    endproperty
    a_low_only_alone: assert property (p_low_only_alone)
        else $error("lowest interrupt taken with others pending");

    property p_fetch;
        @(posedge ref_clk) disable iff (!rst_n)
        (irq_ack && irq_pending) |=> fetch_valid &&
        fetch_addr == $past(vector_base) + {17'h0, $past(irq_vector), 1'b0};
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("fetch address not base plus twice vector");

    property p_base_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        !$past(vbase_we) |-> $stable(vector_base);
    endproperty
    a_base_hold: assert property (p_base_hold)
        else $error("vector base changed without write");

    property p_clk_synth;
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_lock_irq || clk_loss_irq) |-> req_eff[17];
    endproperty
    a_clk_synth: assert property (p_clk_synth)
        else $error("clock synthesis request lost");

    property p_per_level;
        @(posedge ref_clk) disable iff (!rst_n)
        (irq_pending && irq_vector >= 6'h10 && irq_vector <= 6'h2C)
        |-> irq_level >= 3'h1 && irq_level <= 3'h3;
    endproperty
    a_per_level: assert property (p_per_level)
        else $error("peripheral level out of range");

    property p_dbg_level;
        @(posedge ref_clk) disable iff (!rst_n)
        (irq_pending && irq_vector >= 6'h06 && irq_vector <= 6'h0A)
        |-> irq_level >= 3'h2;
    endproperty
    a_dbg_level: assert property (p_dbg_level)
        else $error("debug level out of range");

    property p_data_ram_hit;
        @(posedge ref_clk) disable iff (!rst_n)
        (data_addr <= 24'h00_07FF) |=> data_hit;
    endproperty
    a_data_ram_hit: assert property (p_data_ram_hit)
        else $error("data RAM not decoded");

    property p_prog_decode;
        @(posedge ref_clk) disable iff (!rst_n)
        (prog_addr <= 24'h00_1FFF ||
         (prog_addr >= 24'h00_8000 && prog_addr <= 24'h00_87FF))
        |=> prog_hit;
    endproperty
    a_prog_decode: assert property (p_prog_decode)
        else $error("program flash or RAM not decoded");

    property p_prog_miss;
        @(posedge ref_clk) disable iff (!rst_n)
        (prog_addr > 24'h00_1FFF && prog_addr < 24'h00_8000) |=> !prog_hit;
    endproperty
    a_prog_miss: assert property (p_prog_miss)
        else $error("program hole decoded");

    c_fetch: cover property (@(posedge ref_clk) disable iff (!rst_n)
        irq_ack && irq_pending ##1 fetch_valid);
    c_core: cover property (@(posedge ref_clk) disable iff (!rst_n)
        irq_pending && irq_level == 3'h4);
    c_low: cover property (@(posedge ref_clk) disable iff (!rst_n)
        irq_pending && irq_vector == 6'h2D);
    c_prog_ram: cover property (@(posedge ref_clk) disable iff (!rst_n)
        p_ram);
endmodule : vpm_top
`default_nettype wire

// ===== dv/vpm_core_model.sv
// core model: acknowledges vector requests and records fetches
`timescale 1ns/1ps
`default_nettype none
module vpm_core_model (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        go,
    input  wire logic        irq_pending,
    input  wire logic        fetch_valid,
    input  wire logic [23:0] fetch_addr,
    output logic             irq_ack,
    output logic [23:0]      last_fetch,
    output logic [7:0]       n_fetch
);
    // ========================================
    // ack only a shown request, one pulse at a time
    // no new ack while a fetch is being reported
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ack <= 1'b0;
        end else begin
            irq_ack <= go & irq_pending & ~irq_ack & ~fetch_valid;
        end
    end
    // ========================================
    // fetched entry holds a jump or call, software's side
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_fetch <= 24'h000000;
            n_fetch    <= 8'h00;
        end else if (fetch_valid) begin
            last_fetch <= fetch_addr;
            n_fetch    <= n_fetch + 8'h01;
        end
    end
endmodule : vpm_core_model
`default_nettype wire

// ===== dv/vpm_top_tb_top.sv
// testbench for the vector priority and memory map block
`timescale 1ns/1ps
`default_nettype none
module vpm_top_tb_top;
    logic        ref_clk, rst_n, go, clk_lock_irq, clk_loss_irq;
    logic [45:0] irq_req;
    logic [1:0]  dbg_level [6];
    logic [1:0]  per_level [46];
    logic        vbase_we, irq_ack, flash_unit_we, data_we;
    logic [23:0] vbase_wdata, prog_addr, data_addr, vector_base, fetch_addr;
    logic [12:0] flash_unit_addr;
    logic [15:0] flash_unit_wdata, data_wdata, prog_rdata, data_rdata;
    logic        irq_pending, fetch_valid, prog_hit, data_hit;
    logic        data_per_sel, data_dbg_sel;
    logic [5:0]  irq_vector;
    logic [2:0]  irq_level;
    logic [23:0] last_fetch;
    logic [7:0]  n_fetch;
    int          err_count, compares;

    vpm_top i_vpm_top (.ref_clk(ref_clk), .rst_n(rst_n), .irq_req(irq_req),
        .dbg_level(dbg_level), .per_level(per_level),
        .clk_lock_irq(clk_lock_irq), .clk_loss_irq(clk_loss_irq),
        .vbase_we(vbase_we), .vbase_wdata(vbase_wdata), .irq_ack(irq_ack),
        .prog_addr(prog_addr), .data_addr(data_addr),
        .flash_unit_we(flash_unit_we), .flash_unit_addr(flash_unit_addr),
        .flash_unit_wdata(flash_unit_wdata), .data_we(data_we),
        .data_wdata(data_wdata), .vector_base(vector_base),
        .irq_pending(irq_pending), .irq_vector(irq_vector),
        .irq_level(irq_level), .fetch_valid(fetch_valid),
        .fetch_addr(fetch_addr), .prog_rdata(prog_rdata),
        .prog_hit(prog_hit), .data_rdata(data_rdata), .data_hit(data_hit),
        .data_per_sel(data_per_sel), .data_dbg_sel(data_dbg_sel));
    vpm_core_model i_vpm_core_model (.ref_clk(ref_clk), .rst_n(rst_n),
        .go(go), .irq_pending(irq_pending), .fetch_valid(fetch_valid),
        .fetch_addr(fetch_addr), .irq_ack(irq_ack),
        .last_fetch(last_fetch), .n_fetch(n_fetch));

    // ========================================
    // shared tasks
    task step;
        @(posedge ref_clk);
        #1;
    endtask : step
    task chk(input logic [23:0] g, input logic [23:0] e);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task conclude;
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    task arb(input logic [45:0] r, input logic [5:0] v);
        irq_req = r;
        step;
        chk(irq_vector, v);
    endtask : arb

    // ========================================
    // scenarios
    task t_reset;
        chk(vector_base, 24'h000000);
        chk(irq_pending, 1'b0);
        $display("test reset done");
    endtask : t_reset
    task t_levels;
        per_level[16] = 2'h2;
        per_level[20] = 2'h1;
        per_level[18] = 2'h1;
        arb(46'h1 << 45, 6'h2D);
        chk(irq_level, vpm_pkg::LVL_LOWEST);
        arb((46'h1 << 45) | (46'h1 << 13), 6'h0D);
        arb((46'h1 << 13) | (46'h1 << 16), 6'h10);
        arb((46'h1 << 16) | (46'h1 << 11), 6'h0B);
        arb((46'h1 << 16) | (46'h1 << 5), 6'h05);
        chk(irq_level, vpm_pkg::LVL_TOP);
        arb((46'h1 << 20) | (46'h1 << 18), 6'h12);
        arb((46'h1 << 13) | (46'h1 << 18), 6'h12);
        per_level[20] = 2'h2;
        arb((46'h1 << 20) | (46'h1 << 18), 6'h14);
        arb(46'h6_0020_C003, 6'h00);
        chk(irq_pending, 1'b0);
        $display("test levels done");
    endtask : t_levels
    task t_debug;
        dbg_level[0] = 2'h3;
        arb((46'h1 << 6) | (46'h1 << 5), 6'h05);
        dbg_level[0] = 2'h1;
        arb((46'h1 << 6) | (46'h1 << 11), 6'h0B);
        arb((46'h1 << 6) | (46'h1 << 12), 6'h06);
        dbg_level[0] = 2'h0;
        arb((46'h1 << 6) | (46'h1 << 12), 6'h06);
        $display("test debug done");
    endtask : t_debug
    task t_clock_unit;
        per_level[17] = 2'h0;
        arb(46'h1 << 17, 6'h00);
        chk(irq_pending, 1'b0);
        clk_loss_irq = 1'b1;
        arb(46'h0, 6'h11);
        clk_loss_irq = 1'b0;
        clk_lock_irq = 1'b1;
        arb(46'h0, 6'h11);
        clk_lock_irq = 1'b0;
        $display("test clock unit done");
    endtask : t_clock_unit
    task t_fetch(input logic [23:0] b, input logic [5:0] v);
        logic [7:0] n0;
        vbase_wdata = b;
        vbase_we = 1'b1;
        step;
        vbase_we = 1'b0;
        step;
        chk(vector_base, b);
        irq_req = 46'h1 << v;
        n0 = n_fetch;
        step;
        go = 1'b1;
        for (int i = 0; i < 10 && n_fetch == n0; i++) step;
        go = 1'b0;
        irq_req = 46'h0;
        chk(last_fetch, b + {17'h0, v, 1'b0});
        chk(n_fetch, n0 + 8'h01);
        $display("test fetch done");
    endtask : t_fetch
    task t_memory;
        flash_unit_addr = 13'h0004;
        flash_unit_wdata = 16'hBEEF;
        flash_unit_we = 1'b1;
        data_addr = 24'h000004;
        data_wdata = 16'h1234;
        data_we = 1'b1;
        step;
        flash_unit_we = 1'b0;
        data_addr = 24'h000800;
        data_wdata = 16'h5555;
        step;
        data_we = 1'b0;
        prog_addr = 24'h000004;
        data_addr = 24'h000004;
        step;
        chk(prog_rdata, 16'hBEEF);
        chk(data_rdata, 16'h1234);
        chk(data_hit, 1'b1);
        prog_addr = 24'h008004;
        data_addr = 24'h000800;
        step;
        chk(prog_rdata, 16'h1234);
        chk(data_hit, 1'b0);
        chk(prog_hit, 1'b1);
        prog_addr = 24'h002000;
        data_addr = 24'h00F000;
        step;
        chk(prog_hit, 1'b0);
        chk(data_per_sel, 1'b1);
        chk(data_dbg_sel, 1'b0);
        data_addr = 24'hFFFF00;
        step;
        chk(data_dbg_sel, 1'b1);
        chk(data_per_sel, 1'b0);
        $display("test memory done");
    endtask : t_memory

    // ========================================
    // clock, watchdog and main sequence
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        #(3000 * 100);
        err_count++;
        conclude;
    end
    initial begin
        {rst_n, go, clk_lock_irq, clk_loss_irq, irq_req} = '0;
        {vbase_we, vbase_wdata, prog_addr, data_addr} = '0;
        {flash_unit_we, flash_unit_addr, flash_unit_wdata} = '0;
        {data_we, data_wdata} = '0;
        err_count = 0;
        compares = 0;
        for (int i = 0; i < 6; i++) dbg_level[i] = 2'h1;
        for (int i = 0; i < 46; i++) per_level[i] = 2'h0;
        repeat (20) step;
        rst_n = 1'b1;
        step;
        t_reset;
        t_levels;
        t_debug;
        t_clock_unit;
        t_fetch(24'h000000, 6'h02);
        t_fetch(24'h000100, 6'h03);
        t_memory;
        conclude;
    end
endmodule : vpm_top_tb_top
`default_nettype wire
